// ### rtl/walk_defines.svh
// Purpose: shared constants of the long-mode table walker
// Assumes: included by the package and every design file
// Notes:   widths, field positions and reset values only
`ifndef WALK_DEFINES_SVH
`define WALK_DEFINES_SVH

// ************************************************************
// widths
// ************************************************************
`define VA_W        64
`define PA_W        52
`define IDX_W       9
`define BASE_W      40
`define TAG_W       12
`define LEN_W       4
`define FQ_W        32
`define CNT_W       16

// ************************************************************
// root pointer and table entry fields
// ************************************************************
`define BASE_HI     51
`define BASE_LO     12
`define WT_BIT      3
`define CD_BIT      4
`define PRESENT_BIT 0
`define LPS_BIT     7
`define ENT_SH      3
`define ROOT_RST    64'h0000000000000000

// ************************************************************
// virtual address fields
// ************************************************************
`define MSB_4LV     47
`define MSB_5LV     56
`define L5_LO       48
`define L4_LO       39
`define L3_LO       30
`define L2_LO       21
`define L1_LO       12

// ************************************************************
// feature query bits
// ************************************************************
`define FQ_5LV_BIT  16
`define FQ_1G_BIT   26

`endif

// ### rtl/walk_pkg.sv
// Purpose: types shared by the table walker files
// Assumes: walk_defines.svh on the include path
// Notes:   carriers are packed structs
package walk_pkg;
`include "walk_defines.svh"

    // ************************************************************
    // enumerations
    // ************************************************************
    typedef enum logic [2:0] {LV5, LV4, LV3, LV2, LV1} level_t;
    typedef enum logic [1:0] {PG_4K, PG_2M, PG_1G} page_size_t;
    typedef enum logic [1:0] {FLT_NONE, FLT_GP, FLT_SS, FLT_PF} fault_t;
    typedef enum logic {ST_IDLE, ST_WAIT} walk_state_t;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [`VA_W-1:0]  vaddr;
        logic [`LEN_W-1:0] len_m1;
        logic              stack;
    } xlat_req_t;

    typedef struct packed {
        logic [`PA_W-1:0]  paddr;
        page_size_t        size;
        fault_t            fault;
        logic [`TAG_W-1:0] tag;
    } xlat_resp_t;

    typedef struct packed {
        logic [`PA_W-1:0] addr;
        logic             write_through;
        logic             no_cache;
    } mem_req_t;

    // nine-bit table index of a level, 512 entries per table
    function automatic logic [`IDX_W-1:0] index_of(input level_t lv, input logic [`VA_W-1:0] va);
        logic [`IDX_W-1:0] idx;
        idx = va[`L1_LO +: `IDX_W];
        case (lv) // [RL18]
            LV5:     idx = va[`L5_LO +: `IDX_W];
            LV4:     idx = va[`L4_LO +: `IDX_W];
            LV3:     idx = va[`L3_LO +: `IDX_W];
            LV2:     idx = va[`L2_LO +: `IDX_W];
            default: idx = va[`L1_LO +: `IDX_W];
        endcase
        return idx;
    endfunction

endpackage

// ### rtl/canon_check.sv
// Purpose: canonical form test of one virtual byte address
// Assumes: top implemented bit is 47, or 56 with five levels
// Notes:   purely combinational
`timescale 1ns/1ps
`include "walk_defines.svh"

module canon_check (
    input  wire logic [`VA_W-1:0] addr,
    input  wire logic             five_level,
    output logic                  ok
);
    // bits from the top implemented bit through bit 63
    wire [`VA_W-1-`MSB_4LV:0] upper4 = addr[`VA_W-1:`MSB_4LV];
    wire [`VA_W-1-`MSB_5LV:0] upper5 = addr[`VA_W-1:`MSB_5LV];

    // all ones or all zeros
    assign ok = five_level ? (&upper5 | ~|upper5) : (&upper4 | ~|upper4); // [RL9] [RL19]
endmodule

// ### rtl/entry_addr.sv
// Purpose: physical address of the next table entry to fetch
// Assumes: tables are 4-Kbyte aligned, entries eight bytes
// Notes:   purely combinational
`timescale 1ns/1ps
`include "walk_defines.svh"

module entry_addr (
    input  wire logic [`BASE_W-1:0] base,
    input  wire walk_pkg::level_t   level,
    input  wire logic [`VA_W-1:0]   vaddr,
    output logic [`PA_W-1:0]        addr
);
    wire [`IDX_W-1:0] idx = walk_pkg::index_of(level, vaddr);

    // base plus index times eight, no adder needed
    assign addr = {base, idx, {`ENT_SH{1'b0}}}; // [RL25] [RL3]
endmodule

// ### rtl/long_mode_page_walk.sv
// Purpose: long-mode translation of virtual to physical addresses
// Assumes: one outstanding table read, memory answers with a pulse
// Notes:   no translation cache held here; fill pulse goes outside
`timescale 1ns/1ps
`include "walk_defines.svh"

// Contract
// [RL1] long mode without extension raises protection fault
// [RL2] map 64-bit virtual to 52-bit physical
// [RL3] table entries are 64 bits wide
// [RL4] level-4 map precedes directory-pointer table
// [RL5] large-page bit picks 4K/2M, size-extension ignored
// [RL6] 1G page ends walk at pointer entry
// [RL7] five-level reported bit 16, level-5 table
// [RL8] five-level only while long mode active
// [RL9] every byte address must be canonical
// [RL10] root points at level-4 or level-5 table
// [RL11] root base bits 51:12, low bits zero
// [RL12] software zeroes unimplemented root base bits
// [RL13] root bit 3 selects write-through
// [RL14] root bit 3 clear means write-back
// [RL15] root bit 4 set means not cacheable
// [RL16] root bits 11:0 give context tag
// [RL17] software zeroes reserved root bits
// [RL18] nine-bit index fields, 12-bit page offset
// [RL19] bits above 56 copy bit 56
// [RL20] 2M page stops at directory entry
// [RL21] 1G page stops, offset bits 29:0
// [RL22] bit 7 set ends walk, clear continues
// [RL23] 1G support bit 26, TRANSLATION_LOOKASIDE_BUFFER counts reported
// [RL24] not-present entry faults, never cached
// [RL25] one level per fetch, base plus index*8
module long_mode_page_walk #(
    parameter bit                FIVE_LEVEL_SUPPORTED = 1'b1,
    parameter bit                ONE_GIG_SUPPORTED    = 1'b1,
    parameter logic [`CNT_W-1:0] TLB_1G_L1            = 16'h0008,
    parameter logic [`CNT_W-1:0] TLB_1G_L2            = 16'h0010
) (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 clk_en,
    input  wire logic                 address_extension_enable,
    input  wire logic                 long_mode_request,
    input  wire logic                 five_level_enable,
    input  wire logic                 context_tag_enable,
    input  wire logic                 root_wr,
    input  wire logic [`VA_W-1:0]     root_wdata,
    input  wire logic                 req_valid,
    input  wire walk_pkg::xlat_req_t  req,
    input  wire logic                 mem_rvalid,
    input  wire logic [`VA_W-1:0]     mem_rdata,
    output logic                      long_mode_active_q,
    output logic                      five_level_q,
    output logic                      mode_fault_q,
    output logic [`VA_W-1:0]          root_q,
    output logic                      req_ready_q,
    output logic                      mem_req_valid_q,
    output walk_pkg::mem_req_t        mem_req_q,
    output logic                      resp_valid_q,
    output walk_pkg::xlat_resp_t      resp_q,
    output logic                      tlb_fill_q,
    output logic [`FQ_W-1:0]          feature_ecx_q,
    output logic [`FQ_W-1:0]          feature_edx_q,
    output logic [`CNT_W-1:0]         tlb_1g_l1_q,
    output logic [`CNT_W-1:0]         tlb_1g_l2_q
);

    // ************************************************************
    // declarations
    // ************************************************************
    walk_pkg::walk_state_t state_q;
    walk_pkg::walk_state_t state_d;
    walk_pkg::level_t      level_q;
    walk_pkg::level_t      start_lv;
    walk_pkg::level_t      next_lv;
    walk_pkg::level_t      walk_lv;
    walk_pkg::xlat_resp_t  resp_d;
    logic [`VA_W-1:0]      vaddr_q;
    logic                  lmreq_q;
    logic                  first_ok;
    logic                  last_ok;
    logic [`PA_W-1:0]      fetch_addr;

    // feature words are constants of the build
    localparam logic [`FQ_W-1:0] FQ_ECX = {{(`FQ_W-1){1'b0}}, FIVE_LEVEL_SUPPORTED} << `FQ_5LV_BIT;
    localparam logic [`FQ_W-1:0] FQ_EDX = {{(`FQ_W-1){1'b0}}, ONE_GIG_SUPPORTED} << `FQ_1G_BIT;

    // ************************************************************
    // mode control
    // ************************************************************
    // activation is taken on the rising request only
    wire act_rise = long_mode_request & ~lmreq_q;
    wire act_ok   = act_rise & address_extension_enable; // [RL1]
    wire act_bad  = act_rise & ~address_extension_enable; // [RL1]

    // five-level control is dead outside long mode
    wire five_now = long_mode_active_q & five_level_enable & FIVE_LEVEL_SUPPORTED; // [RL8] [RL7]

    // ************************************************************
    // request side
    // ************************************************************
    wire accept = req_valid & req_ready_q;
    wire [`VA_W-1:0] last_byte = req.vaddr + {{(`VA_W-`LEN_W){1'b0}}, req.len_m1};
    wire canon_ok   = first_ok & last_ok; // [RL9]
    wire start_walk = accept & long_mode_active_q & canon_ok;

    // both ends of the reference; a span crossing the hole fails at its end
    canon_check u_first (
        .addr       (req.vaddr),
        .five_level (five_now),
        .ok         (first_ok)
    );
    canon_check u_last (
        .addr       (last_byte),
        .five_level (five_now),
        .ok         (last_ok)
    );

    // ************************************************************
    // entry decode
    // ************************************************************
    // size-extension control has no input: long mode always uses bit 7
    wire hit     = (state_q == walk_pkg::ST_WAIT) & mem_rvalid;
    wire present = mem_rdata[`PRESENT_BIT];
    wire lps     = mem_rdata[`LPS_BIT];
    wire end_1g  = (level_q == walk_pkg::LV3) & lps & ONE_GIG_SUPPORTED; // [RL6] [RL22]
    wire end_2m  = (level_q == walk_pkg::LV2) & lps; // [RL5] [RL22]
    wire end_4k  = (level_q == walk_pkg::LV1);
    wire leaf    = end_1g | end_2m | end_4k;
    wire step    = hit & present & ~leaf; // [RL22]
    wire done    = hit & (~present | leaf);
    wire [`BASE_W-1:0] ent_base = mem_rdata[`BASE_HI:`BASE_LO];

    // physical page plus page offset for each size
    wire [`PA_W-1:0] pa_4k = {mem_rdata[`BASE_HI:`L1_LO], vaddr_q[`L1_LO-1:0]}; // [RL18] [RL2]
    wire [`PA_W-1:0] pa_2m = {mem_rdata[`BASE_HI:`L2_LO], vaddr_q[`L2_LO-1:0]}; // [RL20]
    wire [`PA_W-1:0] pa_1g = {mem_rdata[`BASE_HI:`L3_LO], vaddr_q[`L3_LO-1:0]}; // [RL21]

    // ************************************************************
    // next fetch address
    // ************************************************************
    // top level is level-5 with five levels on, else level-4
    assign start_lv = five_now ? walk_pkg::LV5 : walk_pkg::LV4; // [RL4] [RL10]
    assign next_lv  = walk_pkg::level_t'(level_q + 3'h1); // [RL25]
    assign walk_lv  = accept ? start_lv : next_lv;
    wire [`BASE_W-1:0] walk_base = accept ? root_q[`BASE_HI:`BASE_LO] : ent_base; // [RL11]
    wire [`VA_W-1:0]   walk_va   = accept ? req.vaddr : vaddr_q;

    entry_addr u_addr (
        .base  (walk_base),
        .level (walk_lv),
        .vaddr (walk_va),
        .addr  (fetch_addr)
    );

    // top table takes the root attributes; lower tables those of the entry
    wire wt_sel = accept ? root_q[`WT_BIT] : mem_rdata[`WT_BIT]; // [RL13] [RL14]
    wire cd_sel = accept ? root_q[`CD_BIT] : mem_rdata[`CD_BIT]; // [RL15]
    wire [`TAG_W-1:0] tag_sel = context_tag_enable ? root_q[`TAG_W-1:0] : {`TAG_W{1'b0}}; // [RL16]

    // ************************************************************
    // response selection
    // ************************************************************
    // outside long mode the address passes untranslated
    always_comb begin
        resp_d       = '0;
        resp_d.size  = walk_pkg::PG_4K;
        resp_d.fault = walk_pkg::FLT_NONE;
        resp_d.tag   = tag_sel;
        if (accept & ~long_mode_active_q) begin
            resp_d.paddr = req.vaddr[`PA_W-1:0];
        end else if (accept & ~canon_ok) begin
            resp_d.fault = req.stack ? walk_pkg::FLT_SS : walk_pkg::FLT_GP; // [RL9]
        end else if (hit & ~present) begin
            resp_d.fault = walk_pkg::FLT_PF; // [RL24]
        end else if (end_1g) begin
            resp_d.paddr = pa_1g;
            resp_d.size  = walk_pkg::PG_1G;
        end else if (end_2m) begin
            resp_d.paddr = pa_2m;
            resp_d.size  = walk_pkg::PG_2M;
        end else begin
            resp_d.paddr = pa_4k;
        end
    end

    wire resp_fire = (accept & ~start_walk) | done;

    // ************************************************************
    // walk state
    // ************************************************************
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            walk_pkg::ST_IDLE: begin
                if (start_walk) begin
                    state_d = walk_pkg::ST_WAIT;
                end
            end
            walk_pkg::ST_WAIT: begin
                if (done) begin
                    state_d = walk_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q     <= walk_pkg::ST_IDLE;
            req_ready_q <= 1'b1;
        end else if (clk_en) begin
            state_q     <= state_d;
            req_ready_q <= (state_d == walk_pkg::ST_IDLE);
        end
    end

    // level and address under walk, one level per fetch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level_q <= walk_pkg::LV4;
            vaddr_q <= '0;
        end else if (clk_en) begin
            if (start_walk | step) begin
                level_q <= walk_lv; // [RL25]
            end
            if (start_walk) begin
                vaddr_q <= req.vaddr;
            end
        end
    end

    // ************************************************************
    // memory request
    // ************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_req_valid_q <= 1'b0;
            mem_req_q       <= '0;
        end else if (clk_en) begin
            mem_req_valid_q <= start_walk | step; // [RL25]
            if (start_walk | step) begin
                mem_req_q <= '{addr: fetch_addr, write_through: wt_sel, no_cache: cd_sel};
            end
        end
    end

    // ************************************************************
    // answer to the core
    // ************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resp_valid_q <= 1'b0;
            tlb_fill_q   <= 1'b0;
            resp_q       <= '0;
        end else if (clk_en) begin
            resp_valid_q <= resp_fire;
            tlb_fill_q   <= hit & present & leaf; // [RL24]
            if (resp_fire) begin
                resp_q <= resp_d;
            end
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    // root is stored as written; zeroing reserved bits is software's job
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            root_q <= `ROOT_RST;
        end else if (clk_en & root_wr) begin
            root_q <= root_wdata; // [RL12] [RL17]
        end
    end

    // dropping the request leaves long mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lmreq_q            <= 1'b0;
            long_mode_active_q <= 1'b0;
            mode_fault_q       <= 1'b0;
            five_level_q       <= 1'b0;
        end else if (clk_en) begin
            lmreq_q            <= long_mode_request;
            long_mode_active_q <= act_ok | (long_mode_active_q & long_mode_request);
            mode_fault_q       <= act_bad; // [RL1]
            five_level_q       <= five_now; // [RL8]
        end
    end

    // ************************************************************
    // feature query words
    // ************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            feature_ecx_q <= FQ_ECX; // [RL7]
            feature_edx_q <= FQ_EDX; // [RL23]
            tlb_1g_l1_q   <= TLB_1G_L1;
            tlb_1g_l2_q   <= TLB_1G_L2;
        end else if (clk_en) begin
            feature_ecx_q <= FQ_ECX;
            feature_edx_q <= FQ_EDX;
            tlb_1g_l1_q   <= TLB_1G_L1; // [RL23]
            tlb_1g_l2_q   <= TLB_1G_L2;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_start;
        clk_en && start_walk;
    endsequence
    sequence s_fetch_out;
        mem_req_valid_q && state_q == walk_pkg::ST_WAIT;
    endsequence

    property p_act_fault;
        clk_en && act_bad |=> mode_fault_q && !long_mode_active_q;
    endproperty
    a_act_fault: assert property (p_act_fault) else $error("activation without extension not faulted"); // [RL1]

    property p_top_base;
        s_start |=> s_fetch_out ##0 mem_req_q.addr[`PA_W-1:`BASE_LO] == $past(root_q[`BASE_HI:`BASE_LO]);
    endproperty
    a_top_base: assert property (p_top_base) else $error("top fetch not at root base"); // [RL11]

    property p_top_attr;
        s_start |=> mem_req_q.write_through == $past(root_q[`WT_BIT])
                    && mem_req_q.no_cache == $past(root_q[`CD_BIT]);
    endproperty
    a_top_attr: assert property (p_top_attr) else $error("top table attributes wrong"); // [RL13]

    property p_top_level;
        s_start |=> level_q == ($past(five_now) ? walk_pkg::LV5 : walk_pkg::LV4);
    endproperty
    a_top_level: assert property (p_top_level) else $error("walk began at wrong level"); // [RL4]

    property p_two_meg;
        clk_en && hit && present && end_2m |=> resp_valid_q && resp_q.size == walk_pkg::PG_2M
            && resp_q.paddr[`L2_LO-1:0] == $past(vaddr_q[`L2_LO-1:0]) && !mem_req_valid_q;
    endproperty
    a_two_meg: assert property (p_two_meg) else $error("2-Mbyte page did not end walk"); // [RL20]

    property p_one_gig;
        clk_en && hit && present && end_1g |=> resp_valid_q && resp_q.size == walk_pkg::PG_1G
            && resp_q.paddr[`L3_LO-1:0] == $past(vaddr_q[`L3_LO-1:0]) ##1 state_q == walk_pkg::ST_IDLE;
    endproperty
    a_one_gig: assert property (p_one_gig) else $error("1-Gbyte page did not end walk"); // [RL21]

    property p_not_present;
        clk_en && hit && !present |=> resp_valid_q && resp_q.fault == walk_pkg::FLT_PF && !tlb_fill_q;
    endproperty
    a_not_present: assert property (p_not_present) else $error("absent entry not faulted"); // [RL24]

    property p_canon;
        clk_en && accept && long_mode_active_q && !canon_ok
            |=> resp_valid_q && resp_q.fault != walk_pkg::FLT_NONE && !mem_req_valid_q;
    endproperty
    a_canon: assert property (p_canon) else $error("non-canonical address was walked"); // [RL9]

    property p_five_off;
        clk_en && !long_mode_active_q |=> !five_level_q;
    endproperty
    a_five_off: assert property (p_five_off) else $error("five levels on outside long mode"); // [RL8]

    property p_step;
        clk_en && step |=> s_fetch_out ##0 level_q == $past(next_lv)
            && mem_req_q.addr[`PA_W-1:`BASE_LO] == $past(ent_base);
    endproperty
    a_step: assert property (p_step) else $error("next level fetch wrong"); // [RL25]

endmodule

// ### dv/table_mem.sv
// Purpose: memory holding the translation tables, answering entry fetches
// Assumes: one fetch outstanding at a time
// Notes:   missing entries read as zero, so they are not present
`timescale 1ns/1ps
module table_mem (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               slow,
    input  wire logic               req_valid,
    input  wire walk_pkg::mem_req_t req,
    output logic                    rvalid,
    output logic [63:0]             rdata
);
    // ************************************************************
    // entry store and answer timing
    // ************************************************************
    logic [63:0] ent [logic [51:0]];
    logic [51:0] addr_q;
    logic [2:0]  wait_q;
    // idle data toggles so a stale entry never passes for an answer
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata  <= 64'h0;
            wait_q <= 3'h0;
            addr_q <= 52'h0;
        end else begin
            rvalid <= 1'b0;
            rdata  <= ~rdata;
            if (req_valid) begin
                addr_q <= req.addr;
                wait_q <= slow ? 3'h4 : 3'h1;
            end else if (wait_q == 3'h1) begin
                rvalid <= 1'b1;
                rdata  <= ent.exists(addr_q) ? ent[addr_q] : 64'h0; // whole 64-bit entry
                wait_q <= 3'h0;
            end else if (wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end
        end
    end
endmodule

// ### dv/tb_top.sv
// Purpose: self-checking bench of the long-mode table walker
// Assumes: table memory model on the fetch port
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
module tb_top;
    // ************************************************************
    // signals, design and memory
    // ************************************************************
    logic clk = 0, resetn = 0, ext = 0, lm_req = 0, fl_en = 0, ct_en = 1, root_wr = 0, req_valid = 0, slow = 0;
    logic [63:0] root_wdata = 64'h0, mem_rdata, root_q;
    logic mem_rvalid, lm_q, fl_q, mf_q, rdy_q, mv_q, rv_q, fill_q;
    logic [31:0] ecx_q, edx_q;
    logic [15:0] t1_q, t2_q;
    logic [1:0] first_att;
    logic [11:0] exp_tag;
    walk_pkg::xlat_req_t req = '0;
    walk_pkg::mem_req_t mreq;
    walk_pkg::xlat_resp_t resp;
    int n_mismatch = 0, comparisons = 0, nfetch = 0, n0 = 0, cyc = 0;
    long_mode_page_walk dut (.clk(clk), .resetn(resetn), .clk_en(1'b1), .address_extension_enable(ext),
        .long_mode_request(lm_req), .five_level_enable(fl_en), .context_tag_enable(ct_en), .root_wr(root_wr),
        .root_wdata(root_wdata), .req_valid(req_valid), .req(req), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .long_mode_active_q(lm_q), .five_level_q(fl_q), .mode_fault_q(mf_q), .root_q(root_q), .req_ready_q(rdy_q),
        .mem_req_valid_q(mv_q), .mem_req_q(mreq), .resp_valid_q(rv_q), .resp_q(resp), .tlb_fill_q(fill_q),
        .feature_ecx_q(ecx_q), .feature_edx_q(edx_q), .tlb_1g_l1_q(t1_q), .tlb_1g_l2_q(t2_q));
    table_mem mem (.clk(clk), .resetn(resetn), .slow(slow), .req_valid(mv_q), .req(mreq), .rvalid(mem_rvalid),
        .rdata(mem_rdata));
    always #2 clk = ~clk;
    // fetch counter and top-table attributes; a cycle ceiling cuts hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mv_q === 1'b1 && nfetch == n0) first_att <= {mreq.write_through, mreq.no_cache};
        if (mv_q === 1'b1) nfetch <= nfetch + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    function automatic logic [51:0] ea(input logic [51:0] b, input logic [8:0] i);
        return b + {43'h0, i} * 52'h8;
    endfunction
    task automatic wr_root(input logic [63:0] v);
        @(negedge clk);
        root_wr = 1;
        root_wdata = v;
        @(negedge clk);
        root_wr = 0;
        @(negedge clk);
        chk(root_q, v);
    endtask
    // one translation; paddr and size only compared when no fault
    task automatic walk(input logic [63:0] va, input logic [3:0] l, input logic s, input logic [51:0] pa,
                        input walk_pkg::page_size_t sz, input walk_pkg::fault_t f, input int n, input logic [1:0] att);
        int i;
        @(negedge clk);
        n0 = nfetch;
        req_valid = 1;
        req = '{vaddr: va, len_m1: l, stack: s};
        // ready is settled here and holds to the taking edge
        while (rdy_q !== 1'b1) @(negedge clk);
        @(negedge clk);
        req_valid = 0;
        for (i = 0; i < 60 && rv_q !== 1'b1; i++) @(negedge clk);
        chk(64'(i < 60), 64'h1);
        chk(64'(resp.fault), 64'(f));
        chk(64'(fill_q), 64'(f == walk_pkg::FLT_NONE));
        chk(64'(resp.tag), 64'(exp_tag));
        chk(64'(nfetch - n0), 64'(n));
        if (n > 0) chk(64'(first_att), 64'(att));
        if (f == walk_pkg::FLT_NONE) chk(64'(resp.paddr), 64'(pa));
        if (f == walk_pkg::FLT_NONE) chk(64'(resp.size), 64'(sz));
    endtask
    // ************************************************************
    // tests
    // ************************************************************
    logic [63:0] va, vb;
    logic mf_seen;
    initial begin
        va = 64'h0000_1234_5678_9ABC;
        vb = 64'h0001_2345_6789_ABCD;
        repeat (4) @(negedge clk);
        resetn = 1;
        chk(root_q, 64'h0);
        chk(64'(rdy_q), 64'h1);
        chk(64'(ecx_q[16]), 64'h1);
        chk(64'(edx_q[26]), 64'h1);
        chk({t2_q, t1_q}, 64'h0010_0008);
        fl_en = 1;
        lm_req = 1;
        mf_seen = 0;
        repeat (3) @(negedge clk) mf_seen |= mf_q;
        chk(64'(mf_seen), 64'h1);
        chk(64'({lm_q, fl_q}), 64'h0);
        lm_req = 0;
        ext = 1;
        repeat (2) @(negedge clk);
        lm_req = 1;
        repeat (3) @(negedge clk);
        chk(64'({lm_q, fl_q}), 64'h3);
        // tables: level-5 at 14000, level-4 at 10000, then 11000, 12000, 13000; zero upper and reserved bits
        mem.ent[ea(52'h14000, vb[56:48])] = 64'h10001;
        mem.ent[ea(52'h10000, vb[47:39])] = 64'h11001;
        mem.ent[ea(52'h10000, va[47:39])] = 64'h11001;
        mem.ent[ea(52'h11000, va[38:30])] = 64'h12001;
        mem.ent[ea(52'h11000, vb[38:30])] = 64'h12001;
        mem.ent[ea(52'h12000, vb[29:21])] = 64'h13001;
        mem.ent[ea(52'h13000, vb[20:12])] = 64'hABCDE001;
        exp_tag = 12'h008;
        wr_root(64'h14008);
        walk(vb, 4'h0, 0, {40'hABCDE, vb[11:0]}, walk_pkg::PG_4K, walk_pkg::FLT_NONE, 5, 2'h2);
        fl_en = 0;
        repeat (3) @(negedge clk);
        walk(vb, 4'h0, 0, 52'h0, walk_pkg::PG_4K, walk_pkg::FLT_GP, 0, 2'h0);
        exp_tag = 12'h010;
        wr_root(64'h10010);
        slow = 1;
        walk(va, 4'h0, 0, 52'h0, walk_pkg::PG_4K, walk_pkg::FLT_PF, 3, 2'h1);
        mem.ent[ea(52'h12000, va[29:21])] = 64'h40200081;
        walk(va, 4'h0, 0, {31'h201, va[20:0]}, walk_pkg::PG_2M, walk_pkg::FLT_NONE, 3, 2'h1);
        slow = 0;
        mem.ent[ea(52'h11000, va[38:30])] = 64'h80000081;
        walk(va, 4'h0, 0, {22'h2, va[29:0]}, walk_pkg::PG_1G, walk_pkg::FLT_NONE, 2, 2'h1);
        walk(64'h0000_7FFF_FFFF_FFFC, 4'h7, 1, 52'h0, walk_pkg::PG_4K, walk_pkg::FLT_SS, 0, 2'h0);
        ct_en = 0;
        exp_tag = 12'h000;
        walk(64'hFFFF_0000_0000_0000, 4'h0, 0, 52'h0, walk_pkg::PG_4K, walk_pkg::FLT_GP, 0, 2'h0);
        summarize();
    end
endmodule
